// [rtl/acsc_pkg.sv]
// package: register layout, codes and timing constants for the converter control
package acsc_pkg;
  localparam logic [7:0] ACSC_CTRL_ADDR    = 8'he8;
  localparam logic [7:0] ACSC_CTRL_RESET   = 8'h00;
  localparam int         ACSC_BIT_ENABLE   = 7;
  localparam int         ACSC_BIT_TRACK    = 6;
  localparam int         ACSC_BIT_DONE     = 5;
  localparam int         ACSC_BIT_BUSY     = 4;
  localparam int         ACSC_BIT_WINDOW   = 3;
  localparam int         ACSC_RES_BITS     = 10;
  localparam int         ACSC_TRACK_CLKS   = 3;
  localparam int         ACSC_CHANNELS     = 21;
  localparam int         ACSC_CH_W         = 5;
  localparam logic [2:0] ACSC_SRC_SW       = 3'h0;
  localparam logic [2:0] ACSC_SRC_T0       = 3'h1;
  localparam logic [2:0] ACSC_SRC_T2       = 3'h2;
  localparam logic [2:0] ACSC_SRC_T1       = 3'h3;
  localparam logic [2:0] ACSC_SRC_EXT      = 3'h4;
  localparam logic [2:0] ACSC_SRC_T3       = 3'h5;
  localparam int         ACSC_SAR_DIV      = 2;

  typedef enum logic [1:0] {
    ACSC_IDLE  = 2'b00,
    ACSC_TRACK = 2'b01,
    ACSC_CONV  = 2'b11
  } acsc_state_t;
endpackage

// [rtl/acsc_sar_if.sv]
// interface between the control sequencer and the sar engine
interface acsc_sar_if;
  logic                           start;
  logic                           busy;
  logic                           done;
  logic [acsc_pkg::ACSC_RES_BITS-1:0] result;
  logic                           sar_tick;
  modport ctrl (output start, input busy, input done, input result,
                output sar_tick);
  modport sar (input start, output busy, output done, output result,
               input sar_tick);
endinterface

// [rtl/acsc_sar.sv]
// successive-approximation engine: one result bit per converter clock
module acsc_sar
  import acsc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_cmp,
  acsc_sar_if.sar   sar
);
  logic [ACSC_RES_BITS-1:0] trial_r;
  logic [ACSC_RES_BITS-1:0] bitpos_r;
  logic                     busy_r;
  logic                     done_r;

  assign sar.busy   = busy_r;
  assign sar.result = trial_r;

  // bit decisions come from the analog comparator against the dac trial
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      trial_r  <= '0;
      bitpos_r <= '0;
      busy_r   <= 1'b0;
    end else if (sar.start && !busy_r) begin
      busy_r   <= 1'b1;
      bitpos_r <= {1'b1, {(ACSC_RES_BITS-1){1'b0}}};
      trial_r  <= {1'b1, {(ACSC_RES_BITS-1){1'b0}}};
    end else if (busy_r && sar.sar_tick) begin
      if (!i_cmp) begin
        trial_r <= trial_r & ~bitpos_r;
      end
      if (bitpos_r[0]) begin
        busy_r <= 1'b0;
      end else begin
        trial_r <= (i_cmp ? trial_r : (trial_r & ~bitpos_r))
                   | (bitpos_r >> 1);
      end
      bitpos_r <= bitpos_r >> 1;
    end
  end

  // done trails by a cycle so the result already holds the last decision
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      done_r <= 1'b0;
    end else begin
      done_r <= busy_r && sar.sar_tick && bitpos_r[0];
    end
  end

  assign sar.done = done_r;
endmodule

// [rtl/acsc_ctrl.sv]
// converter control register, start-source select and tracking sequencer
// Behaviour
// - eight-bit control register, reset all zeros
// - enable clear holds converter in shutdown
// - six start sources supported
// - start-source field picks trigger, 11x reserved
// - low-power mode tracks three converter clocks; with external start it tracks while the pin is low
// - normal mode tracks continuously except converting
// - busy while converting; done on busy fall
// - mux picks positive and negative inputs
// - ten-bit successive-approximation result
module acsc_ctrl
  import acsc_pkg::*;
#(
  parameter int SAR_DIV = ACSC_SAR_DIV
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_resetn,
  input  wire logic [7:0]               i_reg_addr,
  input  wire logic                     i_reg_wr,
  input  wire logic [7:0]               i_reg_wdata,
  output logic [7:0]                    o_reg_rdata,
  input  wire logic                     i_tmr0_ovf,
  input  wire logic                     i_tmr1_ovf,
  input  wire logic                     i_tmr2_ovf,
  input  wire logic                     i_tmr3_ovf,
  input  wire logic                     i_ext_convert_start,
  input  wire logic                     i_cmp,
  input  wire logic                     i_window_hit,
  input  wire logic [ACSC_CH_W-1:0]     i_pos_sel,
  input  wire logic [ACSC_CH_W-1:0]     i_neg_sel,
  output logic                          o_shutdown,
  output logic                          o_track,
  output logic [ACSC_CH_W-1:0]          o_pos_ch,
  output logic [ACSC_CH_W-1:0]          o_neg_ch,
  output logic [ACSC_RES_BITS-1:0]      o_result,
  output logic                          o_result_valid
);
  acsc_sar_if sif ();

  logic                     conv_enable_r;
  logic                     track_mode_select_r;
  logic                     conv_done_flag_r;
  logic                     window_match_flag_r;
  logic [2:0]               start_source_select_r;
  logic                     ext_d_r;
  logic [7:0]               div_r;
  logic                     tick;
  logic [1:0]               trk_cnt_r;
  acsc_state_t              state_r;
  logic                     ctrl_wr;
  logic                     sw_start;
  logic                     trig;
  logic                     ext_rise;
  logic                     start_r;
  logic                     sar_resetn;

  // only the control register address is decoded; other writes pass by
  assign ctrl_wr  = i_reg_wr && (i_reg_addr == ACSC_CTRL_ADDR);
  // busy write of zero has no effect
  assign sw_start = ctrl_wr && i_reg_wdata[ACSC_BIT_BUSY];
  assign ext_rise = i_ext_convert_start && !ext_d_r;

  // trigger select; reserved codes never fire
  always_comb begin
    case (start_source_select_r)
      ACSC_SRC_SW:  trig = sw_start;
      ACSC_SRC_T0:  trig = i_tmr0_ovf;
      ACSC_SRC_T2:  trig = i_tmr2_ovf;
      ACSC_SRC_T1:  trig = i_tmr1_ovf;
      ACSC_SRC_EXT: trig = ext_rise;
      ACSC_SRC_T3:  trig = i_tmr3_ovf;
      default:      trig = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      // idle-high reset level, so a high pin gives no false edge
      ext_d_r <= 1'b1;
    end else begin
      ext_d_r <= i_ext_convert_start;
    end
  end

  // converter clock divider, held off in shutdown to save power
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !conv_enable_r) begin
      div_r <= '0;
    end else if (div_r == 8'(SAR_DIV - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end
  // tick stays low in shutdown, where the sequencer and engine are held in reset
  assign tick         = conv_enable_r && (div_r == 8'(SAR_DIV - 1));
  assign sif.sar_tick = tick;
  assign sif.start    = start_r;

  // control register fields
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      conv_enable_r         <= ACSC_CTRL_RESET[ACSC_BIT_ENABLE];
      track_mode_select_r   <= ACSC_CTRL_RESET[ACSC_BIT_TRACK];
      start_source_select_r <= ACSC_CTRL_RESET[2:0];
    end else if (ctrl_wr) begin
      conv_enable_r         <= i_reg_wdata[ACSC_BIT_ENABLE];
      track_mode_select_r   <= i_reg_wdata[ACSC_BIT_TRACK];
      start_source_select_r <= i_reg_wdata[2:0];
    end
  end

  // sticky flags: hardware set wins over a software clear
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      conv_done_flag_r    <= 1'b0;
      window_match_flag_r <= 1'b0;
    end else begin
      if (sif.done) begin
        conv_done_flag_r <= 1'b1;
      end else if (ctrl_wr && !i_reg_wdata[ACSC_BIT_DONE]) begin
        conv_done_flag_r <= 1'b0;
      end
      if (sif.done && i_window_hit) begin
        window_match_flag_r <= 1'b1;
      end else if (ctrl_wr && !i_reg_wdata[ACSC_BIT_WINDOW]) begin
        window_match_flag_r <= 1'b0;
      end
    end
  end

  // sequencer: idle -> (track) -> convert
  // a trigger landing while tracking or converting is dropped, not queued
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !conv_enable_r) begin
      state_r   <= ACSC_IDLE;
      trk_cnt_r <= '0;
      start_r   <= 1'b0;
    end else begin
      start_r <= 1'b0;
      case (state_r)
        ACSC_IDLE: begin
          if (trig) begin
            if (track_mode_select_r
                && start_source_select_r != ACSC_SRC_EXT) begin
              state_r   <= ACSC_TRACK;
              trk_cnt_r <= '0;
            end else begin
              state_r <= ACSC_CONV;
              start_r <= 1'b1;
            end
          end
        end
        ACSC_TRACK: begin
          if (tick) begin
            if (trk_cnt_r == 2'(ACSC_TRACK_CLKS - 1)) begin
              state_r <= ACSC_CONV;
              start_r <= 1'b1;
            end else begin
              trk_cnt_r <= trk_cnt_r + 2'h1;
            end
          end
        end
        ACSC_CONV: begin
          if (sif.done) begin
            state_r <= ACSC_IDLE;
          end
        end
        default: state_r <= ACSC_IDLE;
      endcase
    end
  end

  // disable aborts a conversion in flight; the engine restarts clean
  assign sar_resetn = i_resetn && conv_enable_r;

  acsc_sar u_sar (
    .i_clk    (i_clk),
    .i_resetn (sar_resetn),
    .i_cmp    (i_cmp),
    .sar      (sif.sar)
  );

  // outputs, all registered
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_reg_rdata    <= ACSC_CTRL_RESET;
      o_shutdown     <= 1'b1;
      o_track        <= 1'b0;
      o_pos_ch       <= '0;
      o_neg_ch       <= '0;
      o_result       <= '0;
      o_result_valid <= 1'b0;
    end else begin
      o_reg_rdata <= {conv_enable_r, track_mode_select_r, conv_done_flag_r,
                      (state_r == ACSC_CONV), window_match_flag_r,
                      start_source_select_r};
      o_shutdown  <= !conv_enable_r;
      // busy reads the sequencer, so it falls as the done flag rises
      if (!conv_enable_r) begin
        o_track <= 1'b0;
      end else if (!track_mode_select_r) begin
        o_track <= (state_r != ACSC_CONV);
      end else if (start_source_select_r == ACSC_SRC_EXT) begin
        o_track <= (state_r != ACSC_CONV) && !i_ext_convert_start;
      end else begin
        o_track <= (state_r == ACSC_TRACK);
      end
      // out-of-range channel codes clamp to channel 0
      o_pos_ch <= (i_pos_sel < ACSC_CH_W'(ACSC_CHANNELS)) ? i_pos_sel
                  : '0;
      o_neg_ch <= (i_neg_sel < ACSC_CH_W'(ACSC_CHANNELS)) ? i_neg_sel
                  : '0;
      o_result_valid <= sif.done;
      if (sif.done) begin
        o_result <= sif.result;
      end
    end
  end
endmodule

// [test/acsc_ctrl_props.sv]
// port assertions for the converter control block
module acsc_ctrl_props
  import acsc_pkg::*;
(
  input wire logic                 i_clk,
  input wire logic                 i_resetn,
  input wire logic [7:0]           i_reg_addr,
  input wire logic                 i_reg_wr,
  input wire logic [7:0]           i_reg_wdata,
  input wire logic [7:0]           o_reg_rdata,
  input wire logic [ACSC_CH_W-1:0] i_pos_sel,
  input wire logic [ACSC_CH_W-1:0] o_pos_ch,
  input wire logic                 o_shutdown,
  input wire logic                 o_track,
  input wire logic                 o_result_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence idle_norm;
    o_reg_rdata[7:6] == 2'b10 && !o_reg_rdata[4];
  endsequence
  // rdata lags the register, so only a start after enable is visible
  sequence sw_go;
    i_reg_wr && i_reg_addr == ACSC_CTRL_ADDR && i_reg_wdata[4] &&
    i_reg_wdata[7] && i_reg_wdata[2:0] == ACSC_SRC_SW &&
    o_reg_rdata[7] && !o_reg_rdata[4];
  endsequence
  reset_vals_a: assert property (disable iff (1'b0)
    !i_resetn |=> o_reg_rdata == ACSC_CTRL_RESET && o_shutdown &&
    !o_track && !o_result_valid) else $error("reset values wrong");
  shutdown_en_a: assert property (
    $stable(o_reg_rdata[7])[*3] |-> o_shutdown == !o_reg_rdata[7])
    else $error("shutdown does not follow enable");
  sw_start_a: assert property (
    sw_go |-> ##[1:8] o_reg_rdata[4]) else $error("software start lost");
  done_fall_a: assert property (
    $fell(o_reg_rdata[4]) |-> o_reg_rdata[5])
    else $error("done not set at busy fall");
  valid_pulse_a: assert property (
    o_result_valid |=> !o_result_valid) else $error("valid too long");
  valid_done_a: assert property (
    o_result_valid |-> ##[0:2] (o_reg_rdata[5] && !o_reg_rdata[4]))
    else $error("result without completion");
  track_idle_a: assert property (
    idle_norm [*3] |-> o_track) else $error("idle normal not tracking");
  rsvd_idle_a: assert property (
    (o_reg_rdata[2:1] == 2'b11 && !o_reg_rdata[4]) ##1
    (o_reg_rdata[2:1] == 2'b11)[*3] |-> !o_reg_rdata[4])
    else $error("reserved code started a conversion");
  ch_map_a: assert property (
    $past(i_resetn) && $stable(i_pos_sel) |-> o_pos_ch ==
    (i_pos_sel < ACSC_CHANNELS ? i_pos_sel : '0))
    else $error("channel select wrong");
endmodule

bind acsc_ctrl acsc_ctrl_props u_props (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .i_pos_sel(i_pos_sel), .o_pos_ch(o_pos_ch),
  .o_shutdown(o_shutdown), .o_track(o_track),
  .o_result_valid(o_result_valid));

// [test/acsc_tmr_model.sv]
// timer overflow, convert-start pin and comparator model
module acsc_tmr_model (
  input  wire logic  i_clk,
  input  wire logic  i_run,
  input  wire logic  i_ext,
  input  wire logic  i_high,
  output logic [3:0] o_ovf = 4'h0,
  output logic       o_ext,
  output logic       o_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt_r = 6'h00;
  // staggered overflows so triggers also land while converting
  always @(posedge i_clk) begin
    cnt_r <= i_run ? cnt_r + 6'h01 : 6'h00;
    for (int k = 0; k < 4; k++)
      o_ovf[k] <= i_run && cnt_r == 6'(k * 9 + 5);
  end
  assign o_ext = i_ext;
  assign o_cmp = i_high;
endmodule

// [test/tb.sv]
// self-checking bench for the converter control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acsc_pkg::*;
  logic       clk = 0, resetn = 0, wr = 0, run = 0, ext = 1, hi = 1, win = 0;
  logic [7:0] addr = ACSC_CTRL_ADDR, wd = 8'h00, rd;
  logic [4:0] pos = 5'h00, neg = 5'h00, pos_ch, neg_ch;
  logic [3:0] ovf;
  logic       ext_pin, cmp, shdn, track, valid;
  logic [9:0] result;
  int         n_errors = 0, n_checks = 0;
  always #20 clk = ~clk;
  acsc_tmr_model u_acsc_tmr_model (.i_clk(clk), .i_run(run), .i_ext(ext),
    .i_high(hi), .o_ovf(ovf), .o_ext(ext_pin), .o_cmp(cmp));
  acsc_ctrl #(.SAR_DIV(1)) u_acsc_ctrl (.i_clk(clk), .i_resetn(resetn),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd), .o_reg_rdata(rd),
    .i_tmr0_ovf(ovf[0]), .i_tmr1_ovf(ovf[1]), .i_tmr2_ovf(ovf[2]),
    .i_tmr3_ovf(ovf[3]), .i_ext_convert_start(ext_pin), .i_cmp(cmp),
    .i_window_hit(win), .i_pos_sel(pos), .i_neg_sel(neg),
    .o_shutdown(shdn), .o_track(track), .o_pos_ch(pos_ch),
    .o_neg_ch(neg_ch), .o_result(result), .o_result_valid(valid));
  task results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ACSC_CTRL_ADDR;
  endtask
  task wait_flag(input int b);
    int k;
    for (k = 0; k < 100 && rd[b] !== 1'b1; k++) tick(1);
    if (k == 100) begin
      n_errors++;
      results();
    end
  endtask
  task s_regs();
    tick(1);
    chk(rd, ACSC_CTRL_RESET);
    chk(shdn, 1'b1);
    wr_reg(ACSC_CTRL_ADDR, 8'h83);
    wr_reg(8'he9, 8'h00);
    pos <= 5'd20;
    neg <= 5'd21;
    tick(2);
    chk(rd, 8'h83);
    chk(shdn, 1'b0);
    chk(track, 1'b1);
    chk(pos_ch, 10'd20);
    chk(neg_ch, 10'd0);
  endtask
  task s_sources();
    logic [2:0] c;
    for (int i = 0; i < 6; i++) begin
      c = i[2:0];
      @(posedge clk);
      hi <= c[0];
      win <= (c == ACSC_SRC_T3);
      wr_reg(ACSC_CTRL_ADDR, {5'b10000, c});
      if (c == ACSC_SRC_SW) wr_reg(ACSC_CTRL_ADDR, 8'h90);
      else if (c == ACSC_SRC_EXT) begin
        ext <= 1'b0;
        repeat (3) @(posedge clk);
        ext <= 1'b1;
      end else run <= 1'b1;
      wait_flag(ACSC_BIT_DONE);
      @(posedge clk);
      run <= 1'b0;
      tick(20);
      chk(result, {10{c[0]}});
      chk(rd[ACSC_BIT_WINDOW], c == ACSC_SRC_T3);
      wr_reg(ACSC_CTRL_ADDR, {5'b10000, c});
      tick(2);
      chk(rd, {5'b10000, c});
    end
  endtask
  task s_reserved();
    for (int i = 6; i < 8; i++) begin
      wr_reg(ACSC_CTRL_ADDR, 8'h80 | 8'(i));
      run <= 1'b1;
      tick(80);
      chk(rd, 8'h80 | 8'(i));
      @(posedge clk);
      run <= 1'b0;
    end
  endtask
  task s_lowpower();
    int n;
    n = 0;
    wr_reg(ACSC_CTRL_ADDR, 8'hc0);
    wr_reg(ACSC_CTRL_ADDR, 8'hd0);
    repeat (30) begin
      tick(1);
      n = n + int'(track);
    end
    chk(n[9:0], 10'(ACSC_TRACK_CLKS));
    wr_reg(ACSC_CTRL_ADDR, 8'hc4);
    ext <= 1'b0;
    tick(5);
    chk(track, 1'b1);
    @(posedge clk);
    ext <= 1'b1;
    wait_flag(ACSC_BIT_DONE);
  endtask
  task s_disabled();
    wr_reg(ACSC_CTRL_ADDR, 8'h00);
    wr_reg(ACSC_CTRL_ADDR, 8'h10);
    tick(4);
    chk(rd, 8'h00);
    chk(shdn, 1'b1);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    s_regs();
    s_sources();
    s_reserved();
    s_lowpower();
    s_disabled();
    results();
  end
endmodule
